// ===== rtl/pocfg_pkg.sv
package pocfg_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0]  CTRL_ADDR     = 8'h00;
  localparam logic [7:0]  PHASE_ADDR    = 8'h04;
  localparam logic [7:0]  STATUS_ADDR   = 8'h08;
  localparam logic [15:0] CTRL_RESET    = 16'h0E88;
  localparam logic [8:0]  PHASE_RESET   = 9'h1FF;
  localparam logic [15:0] CTRL_WMASK    = 16'h7FFF;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SEL_LSB     = 0;
  localparam int SEL_W       = 3;
  localparam int DIS_LSB     = 9;
  localparam int LATCH_LSB   = 12;
  localparam int N_OUT       = 3;
  localparam int N_PHASE     = 3;
  localparam int PWR_W       = 16;
  localparam int ACC_W       = 24;

  // ------------------------------------------------------------
  // Quantity codes
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    POCFG_TOTAL_ACTIVE   = 3'b000,
    POCFG_TOTAL_REACTIVE = 3'b001,
    POCFG_APPARENT       = 3'b010,
    POCFG_FUND_ACTIVE    = 3'b011,
    POCFG_FUND_REACTIVE  = 3'b100
  } pocfg_qty_e;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== rtl/pocfg_top.sv
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

// Summary of operation
// R1 - First selector, reset 000, picks quantity 000..100 summed over its phases
// R2 - First selector codes 101,110,111 produce no first output pulses
// R3 - Second selector in bits 5:3, reset 001, same codes for second output
// R4 - Second selector codes 101,110,111 produce no second output pulses
// R5 - Third selector in bits 8:6, reset 010, same codes for third output
// R6 - Third selector codes 101,110,111 produce no third output pulses
// R7 - Bit 9, reset 1, disables first pin; converter keeps running
// R8 - Bit 10, reset 1, disables second pin; converter keeps running
// R9 - Bit 11, reset 1, disables third pin; converter keeps running
// R10 - Bit 12 set latches first output energies at each pulse; reset clear
// R11 - Bit 13 set latches second output energies at each pulse; reset clear
// R12 - Bit 14 set latches third output energies at each pulse; reset clear
// R13 - Bit 15 resets to zero and affects nothing
// R14 - Three phase bits per output include each phase in its sum
// R15 - Field writes act on later pulses without reset
module pocfg_top #(
  parameter int unsigned PULSE_THRESHOLD = 32'h000F_4240
)(
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic [pocfg_pkg::PWR_W-1:0] power_in [5][3],
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [2:0]                       pulse_out,
  output logic [2:0]                       energy_latch
);
  import pocfg_pkg::*;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [15:0]       pulse_output_control;
  logic [15:0]       next_control;
  logic [8:0]        phase_select;
  logic [8:0]        next_phase;
  logic [2:0]        pulse_seen;
  logic [2:0]        next_seen;

  // ------------------------------------------------------------
  // Bus state
  // ------------------------------------------------------------
  logic              aw_held;
  logic              next_aw_held;
  logic [7:0]        aw_addr;
  logic [7:0]        next_aw_addr;
  logic              w_held;
  logic              next_w_held;
  logic [31:0]       w_data;
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;
  logic [3:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              do_write;
  logic [15:0]       merged;
  logic              next_awready;
  logic              next_wready;
  logic              next_arready;

  // ------------------------------------------------------------
  // Converter state
  // ------------------------------------------------------------
  logic [ACC_W-1:0]  acc [N_OUT];
  logic [ACC_W-1:0]  next_acc [N_OUT];
  logic [N_OUT-1:0]  conv_pulse;
  logic [N_OUT-1:0]  next_pulse_out;
  logic [N_OUT-1:0]  next_latch;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  // Address and data are captured independently; the write fires once
  // both are held and no response is pending, so either order works.
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_control = pulse_output_control;
    next_phase   = phase_select;
    merged       = pulse_output_control;
    do_write     = aw_held && w_held && !s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (w_strb[0])
        merged[7:0] = w_data[7:0];
      if (w_strb[1])
        merged[15:8] = w_data[15:8];
      if (aw_addr[7:2] == CTRL_ADDR[7:2])
        next_control = merged & CTRL_WMASK;  // R13 R15
      else if (aw_addr[7:2] == PHASE_ADDR[7:2])
      begin
        if (w_strb[0])
          next_phase[7:0] = w_data[7:0];  // R14
        if (w_strb[1])
          next_phase[8] = w_data[8];
      end
      // Status writes are dropped with OKAY; unknown offsets get SLVERR
      else if (aw_addr[7:2] != STATUS_ADDR[7:2])
        next_bresp = RESP_SLVERR;
    end
    // Ready drops for a cycle after each handshake: half the bus rate,
    // but a held item can never be overwritten by the next one
    next_awready = !next_aw_held && !s_axi_awready;
    next_wready  = !next_w_held && !s_axi_wready;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      aw_held              <= 1'b0;
      aw_addr              <= 8'h00;
      w_held               <= 1'b0;
      w_data               <= 32'h0000_0000;
      w_strb               <= 4'h0;
      s_axi_awready        <= 1'b0;
      s_axi_wready         <= 1'b0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= RESP_OKAY;
      pulse_output_control <= CTRL_RESET;  // R1 R3 R5 R7 R8 R9 R10 R11 R12
      phase_select         <= PHASE_RESET;
    end
    else
    begin
      aw_held              <= next_aw_held;
      aw_addr              <= next_aw_addr;
      w_held               <= next_w_held;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      s_axi_awready        <= next_awready;
      s_axi_wready         <= next_wready;
      s_axi_bvalid         <= next_bvalid;
      s_axi_bresp          <= next_bresp;
      pulse_output_control <= next_control;
      phase_select         <= next_phase;
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  // A read is refused while its answer waits, so rdata never changes
  // under a master that is slow to take it.
  always_comb
  begin
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr[7:2])
        CTRL_ADDR[7:2]:   next_rdata = {16'h0000, pulse_output_control};
        PHASE_ADDR[7:2]:  next_rdata = {23'h00_0000, phase_select};
        STATUS_ADDR[7:2]: next_rdata = {29'h0000_0000, pulse_seen};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid && !s_axi_arready;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ------------------------------------------------------------
  // Energy-to-frequency converters
  // ------------------------------------------------------------
  // The converter accumulates regardless of the pin disable, so a
  // re-enabled pin resumes in phase with the energy already counted.
  // ACC_W must exceed the threshold's width; the default leaves headroom.
  for (genvar g = 0; g < N_OUT; g++)
  begin : g_out
    logic [2:0]       sel;
    logic [2:0]       phs;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] step;
    logic             valid_sel;
    assign sel = pulse_output_control[SEL_LSB+g*SEL_W +: SEL_W];  // R1 R3 R5
    assign phs = phase_select[g*N_PHASE +: N_PHASE];
    // A reserved code freezes the accumulator instead of clearing it
    assign valid_sel = (sel <= 3'(POCFG_FUND_REACTIVE));  // R2 R4 R6

    always_comb
    begin
      sum = '0;
      for (int p = 0; p < N_PHASE; p++)
        if (phs[p] && valid_sel)
          sum = sum + ACC_W'(power_in[sel][p]);  // R14
      step = acc[g] + sum;
      conv_pulse[g] = valid_sel && (step >= ACC_W'(PULSE_THRESHOLD));
      next_acc[g] = conv_pulse[g] ? step - ACC_W'(PULSE_THRESHOLD) : step;
      next_pulse_out[g] = conv_pulse[g]
                        && !pulse_output_control[DIS_LSB+g];  // R7 R8 R9
      next_latch[g] = conv_pulse[g]
                    && pulse_output_control[LATCH_LSB+g];  // R10 R11 R12
    end
  end

  // Pins and latch strobes stay low through reset
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i < N_OUT; i++)
        acc[i] <= '0;
      pulse_out    <= 3'b000;
      energy_latch <= 3'b000;
    end
    else
    begin
      for (int i = 0; i < N_OUT; i++)
        acc[i] <= next_acc[i];
      pulse_out    <= next_pulse_out;
      energy_latch <= next_latch;
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  // Sticky, so software sees a converter ran even with its pin disabled;
  // only a reset clears them.
  always_comb
  begin
    next_seen = pulse_seen | conv_pulse;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pulse_seen <= 3'b000;
    end
    else
    begin
      pulse_seen <= next_seen;
    end
  end

endmodule

// ===== bench/pocfg_assertions.sv
`timescale 1ns/1ps
// ----------
// Port checks
// ----------
module pocfg_assertions (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [2:0] pulse_out,
  input wire logic [2:0] energy_latch
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Reset must leave pins quiet: pulse pins and latch strobes low the cycle after srst
  reset_quiet_a: assert property (disable iff (1'b0)
    srst |=> pulse_out == 3'h0 && energy_latch == 3'h0) else $error("pins busy in reset");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready
    |-> ##[1:8] s_axi_bvalid) else $error("write unanswered");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read unanswered");
  bresp_clear_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write response repeated");
  rresp_clear_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read response repeated");
  aw_spacing_a: assert property (s_axi_awready
    |=> !s_axi_awready) else $error("awready high twice");
  read_block_a: assert property (s_axi_rvalid
    |-> !s_axi_arready) else $error("read taken while pending");
  rresp_code_a: assert property (s_axi_rvalid
    |-> s_axi_rresp inside {2'h0, 2'h2}) else $error("bad read code");
  cover property (pulse_out[0]);
  cover property (energy_latch[2]);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind pocfg_top pocfg_assertions chk_u (.clock, .srst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp,
  .pulse_out, .energy_latch);

// ===== bench/pocfg_pulse_counter.sv
`timescale 1ns/1ps
// ----------
// Meter test counter on the pulse pins
// ----------
module pocfg_pulse_counter (
  input  wire logic       clock,
  input  wire logic       clear,
  input  wire logic [2:0] pulse_out,
  input  wire logic [2:0] energy_latch,
  output int              pulse_cnt [3],
  output int              latch_cnt [3]
);
  // A pin stuck high counts every cycle, so it cannot hide
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < 3; i++)
    begin
      pulse_cnt[i] <= clear ? 0
                    : pulse_cnt[i] + ((pulse_out[i] === 1'b0) ? 0 : 1);
      latch_cnt[i] <= clear ? 0
                    : latch_cnt[i] + ((energy_latch[i] === 1'b0) ? 0 : 1);
    end
  end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pocfg_pkg::*;
  logic             clock, srst, clear;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]       s_axi_wstrb;
  logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic             s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic             s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp, resp;
  logic [2:0]       pulse_out, energy_latch;
  logic [PWR_W-1:0] power_in [5][3];
  int               error_cnt = 0;
  int               checks = 0;
  int               pulse_cnt [3];
  int               latch_cnt [3];
  // Small threshold keeps each measuring window short
  pocfg_top #(.PULSE_THRESHOLD(100)) dut_u (.clock, .srst, .power_in,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulse_out,
    .energy_latch);
  pocfg_pulse_counter meter_u (.clock, .clear, .pulse_out, .energy_latch,
    .pulse_cnt, .latch_cnt);
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic give_verdict;
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk(n < 100, "write hangs");
    if (n >= 100) give_verdict();
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    {rd, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    chk(n < 100, "read hangs");
    if (n >= 100) give_verdict();
  endtask
  // Code pc feeds 20 per phase to quantity pc only; above 4 feeds all
  task automatic measure(input logic [15:0] c, input logic [8:0] ph,
                         input int pc, input int ep [3], input int el [3]);
    for (int q = 0; q < 5; q++)
      for (int p = 0; p < 3; p++)
        power_in[q][p] <= (pc > 4 || q == pc) ? 16'h0014 : 16'h0000;
    axw(CTRL_ADDR, {16'h0000, c});
    chk(resp === RESP_OKAY, "control write code");
    axw(PHASE_ADDR, {23'h00_0000, ph});
    chk(resp === RESP_OKAY, "phase write code");
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (50) @(posedge clock);
    for (int i = 0; i < 3; i++)
    begin
      chk(ep[i] == 0 ? pulse_cnt[i] == 0 : pulse_cnt[i] inside
          {[ep[i] - 1:ep[i] + 1]}, "pulse count");
      chk(el[i] == 0 ? latch_cnt[i] == 0 : latch_cnt[i] inside
          {[el[i] - 1:el[i] + 1]}, "latch count");
    end
  endtask
  task automatic defaults_check;
    axr(CTRL_ADDR);
    chk(rd === 32'h0000_0E88 && resp === RESP_OKAY, "control default");
    axr(PHASE_ADDR);
    chk(rd === 32'h0000_01FF, "phase default");
    measure(16'h0E88, 9'h1FF, 7, '{0, 0, 0}, '{0, 0, 0});
  endtask
  task automatic code_sweep;
    int e [3];
    for (int c = 0; c < 8; c++)
    begin
      e = '{30, 30, 30};
      if (c > 4)
        e = '{0, 0, 0};
      measure({7'h38, c[2:0], c[2:0], c[2:0]}, 9'h1FF, c, e, e);
    end
    e = '{30, 0, 0};
    measure({7'h38, 3'h4, 3'h1, 3'h0}, 9'h1FF, 0, e, e);
  endtask
  task automatic gate_and_spare;
    measure(16'h7E00, 9'h1FF, 0, '{0, 0, 0}, '{30, 30, 30});
    measure(16'h8000, 9'h1FF, 0, '{30, 30, 30}, '{0, 0, 0});
    axr(CTRL_ADDR);
    chk(rd === 32'h0000_0000, "spare bit reads back");
    measure(16'h7000, 9'h1D9, 0, '{10, 20, 30}, '{10, 20, 30});
  endtask
  task automatic unmapped_check;
    axw(8'h0C, 32'h0000_FFFF);
    chk(resp === RESP_SLVERR, "unmapped write code");
    axr(8'h0C);
    chk(resp === RESP_SLVERR && rd === 32'h0000_0000, "unmapped read");
    axr(STATUS_ADDR);
    chk(rd === 32'h0000_0007 && resp === RESP_OKAY, "status flags");
  endtask
  initial
  begin
    {srst, clear, s_axi_wstrb} = 6'h3F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
    s_axi_wdata = 32'h0000_0000;
    for (int q = 0; q < 5; q++)
      for (int p = 0; p < 3; p++)
        power_in[q][p] = 16'h0000;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    defaults_check();
    code_sweep();
    gate_and_spare();
    unmapped_check();
    give_verdict();
  end
endmodule
